// >>> pkg/status_word_pkg.sv
// Constants and types for the drive status word logic
//
// What this block does
// [RL1] Ready to switch on follows control bit 10.
// [RL2] Ready for operation set by control bit 0 from ready to switch on.
// [RL3] Operation enabled set by control bit 3 from ready for operation.
// [RL4] Fault set by error at ready for operation or higher; cleared on bit 7 fall.
// [RL5] Bits 4, 5, 9, 11 set on detection or required; cleared at test start.
// [RL6] Switch-on inhibit set on bit 7 fall in fault; cleared on bit 0 fall.
// [RL7] Warning set on any error, cleared once all errors are gone.
// [RL8] While fault is active, warning clears only together with fault.
// [RL9] No drag error follows drag window during movement; cleared at test start.
// [RL10] Target reached set on arrival, cleared at start of a positioning run.
// [RL11] Target reached cleared below ready for operation, kept in fault or inhibit.
// [RL12] Acknowledge bit copies control bit 6 at movement start; cleared below ready.
// [RL13] New movement starts only when control bit 6 differs from acknowledge bit.
// [RL14] Standstill set when a run completes, cleared when a run begins.
// [RL15] Overcurrent sets bit 14, and fault except in switch-on inhibit; cleared on fault acknowledge.
// [RL16] Position limit bit set while position lies outside the range limits.
// [RL17] States ordered not ready, ready to switch on, ready, enabled.
`default_nettype none
package status_word_pkg;

  // Status word bit positions
  localparam int unsigned SB_RTSO  = 0;
  localparam int unsigned SB_RFO   = 1;
  localparam int unsigned SB_OPEN  = 2;
  localparam int unsigned SB_FAULT = 3;
  localparam int unsigned SB_COAST = 4;
  localparam int unsigned SB_QUICK = 5;
  localparam int unsigned SB_INHIB = 6;
  localparam int unsigned SB_WARN  = 7;
  localparam int unsigned SB_NODRG = 8;
  localparam int unsigned SB_CTREQ = 9;
  localparam int unsigned SB_TGTR  = 10;
  localparam int unsigned SB_REFS  = 11;
  localparam int unsigned SB_ACK   = 12;
  localparam int unsigned SB_STILL = 13;
  localparam int unsigned SB_OVCUR = 14;
  localparam int unsigned SB_LIMIT = 15;

  // Control word bit positions
  localparam int unsigned CB_ON    = 0;
  localparam int unsigned CB_ENOP  = 3;
  localparam int unsigned CB_RUN   = 6;
  localparam int unsigned CB_ACKF  = 7;
  localparam int unsigned CB_CTRL  = 10;

  // Reset value of the status word
  localparam logic [15:0] STATUS_RESET = 16'h0000;

  // Drive states, ordered so that magnitude comparisons work
  typedef enum logic [2:0] {
    ST_NOT_READY,
    ST_READY_SWON,
    ST_READY_OP,
    ST_OP_ENABLED,
    ST_FAULT,
    ST_INHIBIT
  } drive_state_e;

  // Events reported by the motion and supervision logic
  typedef struct packed {
    logic error_any;    // At least one error present (level)
    logic overcurrent;  // Motor current above maximum (level)
    logic presence_start;// Presence test begins (pulse)
    logic presence_found;// Drive detected or marked required (pulse)
    logic in_drag_win;  // Position difference inside drag window (level)
    logic moving;       // A movement is under way (level)
    logic arrived;      // Target position reached (pulse)
    logic run_done;     // Run completed (pulse)
    logic out_of_range; // Actual position outside limits (level)
  } motion_ev_s;

endpackage : status_word_pkg
`default_nettype wire

// >>> rtl/edge_fall.sv
// Falling edge detector for control word bits
`timescale 1ns/1ps
`default_nettype none
module edge_fall #(
  parameter int unsigned W = 16  // Number of bits watched
) (
  input  wire logic         clk_sys, // System clock
  input  wire logic         resetn,  // Asynchronous reset, active low
  input  wire logic [W-1:0] din,     // Bits watched
  output logic      [W-1:0] fall     // One-cycle pulse on a falling edge
);
  logic [W-1:0] prev_q;

  // Previous value of every bit
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prev_q <= '0;
    end else begin
      prev_q <= din;
    end
  end

  assign fall = prev_q & ~din;
endmodule : edge_fall
`default_nettype wire

// >>> rtl/run_start.sv
// Run start decision from the toggle handshake
`timescale 1ns/1ps
`default_nettype none
module run_start (
  input  wire logic run_toggle,  // Control bit 6
  input  wire logic ack_bit,     // Current status bit 12
  input  wire logic ready,       // State at least ready for operation
  input  wire logic idle,        // No movement under way
  output logic      start        // One-cycle start request
);
  // [RL13] toggle start condition
  assign start = ready & idle & (run_toggle != ack_bit);
endmodule : run_start
`default_nettype wire

// >>> rtl/drive_status_word_logic.sv
// Drive state machine and status word generation
`timescale 1ns/1ps
`default_nettype none
module drive_status_word_logic
  import status_word_pkg::*;
(
  input  wire logic                       clk_sys,      // 20 MHz system clock
  input  wire logic                       resetn,       // Asynchronous reset, active low
  input  wire logic [15:0]                control_word, // Control word from controller
  input  wire status_word_pkg::motion_ev_s ev,          // Motion and supervision events
  output logic                            run_start_p,  // Pulse: start a movement
  output logic [15:0]                     drive_status_word // Status word to controller
);
  import status_word_pkg::*;

  drive_state_e state_q;
  drive_state_e state_d;
  logic [15:0]  fall;
  logic         ack_fall;
  logic         on_fall;
  logic         fault_q;
  logic         warn_q;
  logic         inhibit_q;
  logic         ovcur_q;
  logic         present_q;
  logic         nodrag_q;
  logic         tgt_q;
  logic         ack_q;
  logic         still_q;
  logic         limit_q;
  logic         at_ready;
  logic         start_w;
  logic         moving_q;

  // Falling edges of all control bits
  edge_fall #(.W(16)) u_fall (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .din     (control_word),
    .fall    (fall)
  );

  assign ack_fall = fall[CB_ACKF];
  assign on_fall  = fall[CB_ON];

  // [RL17] ready or higher: ready for operation or operation enabled
  assign at_ready = (state_q == ST_READY_OP) || (state_q == ST_OP_ENABLED);

  // Start decision, only when no movement runs
  run_start u_start (
    .run_toggle (control_word[CB_RUN]),
    .ack_bit    (ack_q),
    .ready      (at_ready),
    .idle       (!moving_q),
    .start      (start_w)
  );

  assign run_start_p = start_w;

  // Next state of the drive profile machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_NOT_READY: begin
        // [RL1] enter ready to switch on
        if (control_word[CB_CTRL]) begin
          state_d = ST_READY_SWON;
        end
      end
      ST_READY_SWON: begin
        if (!control_word[CB_CTRL]) begin
          state_d = ST_NOT_READY;
        // [RL2] enter ready for operation
        end else if (control_word[CB_ON]) begin
          state_d = ST_READY_OP;
        end
      end
      ST_READY_OP: begin
        if (!control_word[CB_CTRL]) begin
          state_d = ST_NOT_READY;
        end else if (!control_word[CB_ON]) begin
          state_d = ST_READY_SWON;
        // [RL3] enter operation enabled
        end else if (control_word[CB_ENOP]) begin
          state_d = ST_OP_ENABLED;
        end
      end
      ST_OP_ENABLED: begin
        if (!control_word[CB_CTRL]) begin
          state_d = ST_NOT_READY;
        end else if (!control_word[CB_ON]) begin
          state_d = ST_READY_SWON;
        end else if (!control_word[CB_ENOP]) begin
          state_d = ST_READY_OP;
        end
      end
      ST_FAULT: begin
        // [RL6] acknowledge leads to inhibit
        if (ack_fall) begin
          state_d = ST_INHIBIT;
        end
      end
      ST_INHIBIT: begin
        if (on_fall) begin
          state_d = ST_NOT_READY;
        end
      end
      default: begin
        state_d = ST_NOT_READY;
      end
    endcase
    // [RL4] error at ready or higher enters fault
    if ((ev.error_any || ev.overcurrent) && at_ready) begin
      state_d = ST_FAULT;
    end
    // [RL15] overcurrent forces fault, except in switch-on inhibit
    if (ev.overcurrent && state_q != ST_FAULT && state_q != ST_INHIBIT) begin
      state_d = ST_FAULT;
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_NOT_READY;
    end else begin
      state_q <= state_d;
    end
  end

  // Fault flag, set wins over acknowledge
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fault_q <= 1'b0;
    end else if (state_d == ST_FAULT && state_q != ST_FAULT) begin
      // [RL4] fault set
      fault_q <= 1'b1;
    end else if (state_q == ST_FAULT && ack_fall) begin
      // [RL4] fault cleared on acknowledge
      fault_q <= 1'b0;
    end
  end

  // Warning flag follows errors, held while fault stands
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      warn_q <= 1'b0;
    end else if (ev.error_any || ev.overcurrent) begin
      // [RL7] warning set on any error
      warn_q <= 1'b1;
    // [RL8] hold while fault active
    end else if (!fault_q || (state_q == ST_FAULT && ack_fall)) begin
      // [RL7] cleared once errors are gone
      warn_q <= 1'b0;
    end
  end

  // Switch-on inhibit flag
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      inhibit_q <= 1'b0;
    end else if (state_q == ST_FAULT && ack_fall) begin
      // [RL6] inhibit set on acknowledge
      inhibit_q <= 1'b1;
    end else if (on_fall) begin
      // [RL6] inhibit cleared on bit 0 fall
      inhibit_q <= 1'b0;
    end
  end

  // Overcurrent flag, set wins over acknowledge
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ovcur_q <= 1'b0;
    end else if (ev.overcurrent) begin
      // [RL15] overcurrent set
      ovcur_q <= 1'b1;
    end else if (state_q == ST_FAULT && ack_fall) begin
      // [RL15] cleared on acknowledge
      ovcur_q <= 1'b0;
    end
  end

  // Presence bits, detection wins over test start
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      present_q <= 1'b0;
    end else if (ev.presence_found) begin
      // [RL5] set on detection
      present_q <= 1'b1;
    end else if (ev.presence_start) begin
      // [RL5] cleared at test start
      present_q <= 1'b0;
    end
  end

  // No drag error flag
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      nodrag_q <= 1'b0;
    end else if (ev.moving && ev.in_drag_win) begin
      // [RL9] set inside drag window, wins over test start
      nodrag_q <= 1'b1;
    end else if (ev.presence_start || ev.moving) begin
      // [RL9] cleared at test start or outside the window
      nodrag_q <= 1'b0;
    end
  end

  // Movement in progress, from start to completion
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      moving_q <= 1'b0;
    end else if (start_w) begin
      moving_q <= 1'b1;
    end else if (ev.run_done || !at_ready) begin
      moving_q <= 1'b0;
    end
  end

  // Target reached flag
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tgt_q <= 1'b0;
    end else if (ev.arrived) begin
      // [RL10] set on arrival, wins over clear
      tgt_q <= 1'b1;
    end else if (start_w) begin
      // [RL10] cleared at run start
      tgt_q <= 1'b0;
    // [RL11] cleared below ready, kept in fault and inhibit
    end else if (state_q == ST_NOT_READY || state_q == ST_READY_SWON) begin
      tgt_q <= 1'b0;
    end
  end

  // Target value acknowledge
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ack_q <= 1'b0;
    end else if (!at_ready) begin
      // [RL12] cleared below ready
      ack_q <= 1'b0;
    end else if (start_w) begin
      // [RL12] copy control bit 6
      ack_q <= control_word[CB_RUN];
    end
  end

  // Standstill flag
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      still_q <= 1'b0;
    end else if (ev.run_done) begin
      // [RL14] set on completion, wins over clear
      still_q <= 1'b1;
    end else if (start_w) begin
      // [RL14] cleared at run start
      still_q <= 1'b0;
    end
  end

  // Position limit flag
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      limit_q <= 1'b0;
    end else begin
      // [RL16] follows range check
      limit_q <= ev.out_of_range;
    end
  end

  // Status word assembly
  always_comb begin
    drive_status_word           = STATUS_RESET;
    drive_status_word[SB_RTSO]  = state_q == ST_READY_SWON || at_ready;
    drive_status_word[SB_RFO]   = at_ready;
    drive_status_word[SB_OPEN]  = state_q == ST_OP_ENABLED;
    drive_status_word[SB_FAULT] = fault_q;
    drive_status_word[SB_COAST] = present_q;
    drive_status_word[SB_QUICK] = present_q;
    drive_status_word[SB_INHIB] = inhibit_q;
    drive_status_word[SB_WARN]  = warn_q;
    drive_status_word[SB_NODRG] = nodrag_q;
    drive_status_word[SB_CTREQ] = present_q;
    drive_status_word[SB_TGTR]  = tgt_q;
    drive_status_word[SB_REFS]  = present_q;
    drive_status_word[SB_ACK]   = ack_q;
    drive_status_word[SB_STILL] = still_q;
    drive_status_word[SB_OVCUR] = ovcur_q;
    drive_status_word[SB_LIMIT] = limit_q;
  end

  // [RL1] ready bit tracks control bit 10
  ready_bit_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_q == ST_NOT_READY && control_word[CB_CTRL] && !ev.error_any && !ev.overcurrent)
    |=> drive_status_word[SB_RTSO])
    else $error("ready to switch on not set");

  // [RL2] ready for operation entry
  ready_op_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_q == ST_READY_SWON && control_word[CB_CTRL] && control_word[CB_ON] && !ev.overcurrent)
    |=> drive_status_word[SB_RFO])
    else $error("ready for operation not set");

  // [RL3] operation enabled clears with bit 3
  op_enable_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_q == ST_OP_ENABLED && !control_word[CB_ENOP] && !ev.error_any && !ev.overcurrent)
    |=> !drive_status_word[SB_OPEN])
    else $error("operation enabled not cleared");

  // [RL4] fault entry from ready
  fault_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (at_ready && ev.error_any) |=> drive_status_word[SB_FAULT])
    else $error("fault not set on error");

  // [RL6] inhibit after acknowledge
  inhibit_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_q == ST_FAULT && ack_fall) |=> inhibit_q && !fault_q)
    else $error("inhibit not set on acknowledge");

  // [RL8] warning held during fault
  warn_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    fault_q |-> warn_q)
    else $error("warning dropped while fault active");

  // [RL12] acknowledge copies bit 6
  ack_copy_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    start_w |=> (ack_q == $past(control_word[CB_RUN])) || !at_ready)
    else $error("acknowledge did not copy bit 6");

  // [RL13] start only on differing toggle
  run_toggle_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    start_w |-> ((control_word[CB_RUN] != ack_q) && at_ready) ##1 !start_w)
    else $error("run started without toggle");

  // [RL15] overcurrent sets bit 14, state then fault or inhibit
  ovcur_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (ev.overcurrent && !(state_q == ST_INHIBIT && on_fall))
    |=> ovcur_q && (state_q == ST_FAULT || state_q == ST_INHIBIT))
    else $error("overcurrent not handled");

endmodule : drive_status_word_logic
`default_nettype wire

// >>> bench/plc_model.sv
// Controller model that writes the control word once a cycle
`timescale 1ns/1ps
`default_nettype none
module plc_model (
  input  wire logic        clk_sys,     // System clock
  input  wire logic        resetn,      // Asynchronous reset, active low
  input  wire logic [15:0] cw_req,      // Wanted control bits, bit 6 ignored
  input  wire logic        run_req,     // Ask for a new run
  input  wire logic [15:0] status_word, // Status word read back
  output logic      [15:0] control_word // Control word to the drive
);
  logic [15:0] cw_q;
  // Cyclic frame register; bit 6 is owned by the run handshake
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cw_q <= 16'h0000;
    end else begin
      cw_q[15:7] <= cw_req[15:7];
      cw_q[5:0]  <= cw_req[5:0];
      if (run_req && (cw_q[6] == status_word[12])) begin
        cw_q[6] <= ~cw_q[6];
      end
    end
  end
  // Frame contents seen by the drive
  assign control_word = cw_q;
endmodule : plc_model
`default_nettype wire

// >>> bench/drive_status_word_logic_tb.sv
// Self-checking testbench for the drive status word logic
`timescale 1ns/1ps
`default_nettype none
module drive_status_word_logic_tb;
  import status_word_pkg::*;
  localparam logic [8:0] M_ERR = 9'h100, M_OVC = 9'h080, M_PST = 9'h040, M_PFD = 9'h020;
  localparam logic [8:0] M_WIN = 9'h010, M_MOV = 9'h008, M_ARR = 9'h004, M_DONE = 9'h002;
  localparam logic [8:0] M_OOR = 9'h001;
  logic        clk_sys;
  logic        resetn;
  logic        run_req;
  logic        run_p;
  logic [15:0] cw_req;
  logic [15:0] control_word;
  logic [15:0] dsw;
  motion_ev_s  ev;
  int          num_errors = 0;
  int          n_tests = 0;
  int          starts = 0;

  plc_model plc_model_inst (
    .clk_sys(clk_sys), .resetn(resetn), .cw_req(cw_req), .run_req(run_req),
    .status_word(dsw), .control_word(control_word)
  );
  drive_status_word_logic drive_status_word_logic_inst (
    .clk_sys(clk_sys), .resetn(resetn), .control_word(control_word), .ev(ev),
    .run_start_p(run_p), .drive_status_word(dsw)
  );

  // Clock at 50 ns period
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Count accepted movement starts
  always @(posedge clk_sys) begin
    if (run_p === 1'b1) starts <= starts + 1;
  end

  task automatic settle();
    @(posedge clk_sys);
    #1;
  endtask : settle

  // Control word reaches the drive one frame later, status one edge after that
  task automatic put(input logic [15:0] v);
    @(posedge clk_sys);
    cw_req <= v;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : put

  task automatic level(input logic [8:0] m, input logic v);
    @(posedge clk_sys);
    ev <= v ? (ev | m) : (ev & ~m);
    settle();
  endtask : level

  task automatic pulse(input logic [8:0] m);
    @(posedge clk_sys);
    ev <= ev | m;
    @(posedge clk_sys);
    ev <= ev & ~m;
    settle();
  endtask : pulse

  task automatic run();
    @(posedge clk_sys);
    run_req <= 1'b1;
    @(posedge clk_sys);
    run_req <= 1'b0;
    settle();
  endtask : run

  task automatic chk_sw(input logic [15:0] mask, input logic [15:0] exp);
    n_tests++;
    if ((dsw & mask) !== exp) begin
      num_errors++;
      $display("BAD %0t status %h mask %h expected %h", $time, dsw, mask, exp);
    end
  endtask : chk_sw

  task automatic chk_n(input int exp);
    n_tests++;
    if (starts != exp) begin
      num_errors++;
      $display("BAD %0t starts %0d expected %0d", $time, starts, exp);
    end
  endtask : chk_n

  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  // Main sequence
  initial begin
    resetn  = 1'b0;
    cw_req  = 16'h0000;
    run_req = 1'b0;
    ev      = '0;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    settle();
    chk_sw(16'hFFFF, 16'h0000);
    put(16'h0400);
    chk_sw(16'h0007, 16'h0001);
    level(M_ERR, 1'b1);
    chk_sw(16'h008F, 16'h0081);
    level(M_ERR, 1'b0);
    chk_sw(16'h008F, 16'h0001);
    put(16'h0401);
    chk_sw(16'h0007, 16'h0003);
    put(16'h0409);
    chk_sw(16'h0007, 16'h0007);
    put(16'h0401);
    chk_sw(16'h0007, 16'h0003);
    put(16'h0400);
    chk_sw(16'h0007, 16'h0001);
    put(16'h0000);
    chk_sw(16'h0007, 16'h0000);
    put(16'h0400);
    put(16'h0401);
    put(16'h0409);
    // First run with arrival and completion
    run();
    chk_n(1);
    chk_sw(16'h3400, 16'h1000);
    level(M_MOV, 1'b1);
    level(M_WIN, 1'b1);
    chk_sw(16'h0100, 16'h0100);
    pulse(M_ARR);
    chk_sw(16'h0400, 16'h0400);
    pulse(M_DONE);
    level(M_MOV, 1'b0);
    chk_sw(16'h2000, 16'h2000);
    repeat (5) settle();
    chk_n(1);
    // Presence test flags
    pulse(M_PFD);
    chk_sw(16'h0A30, 16'h0A30);
    pulse(M_PST);
    chk_sw(16'h0B30, 16'h0000);
    // Second run clears arrival and standstill, acknowledge follows bit 6
    run();
    chk_n(2);
    chk_sw(16'h3400, 16'h0000);
    level(M_MOV, 1'b1);
    level(M_WIN, 1'b1);
    level(M_WIN, 1'b0);
    chk_sw(16'h0100, 16'h0000);
    pulse(M_ARR);
    pulse(M_DONE);
    level(M_MOV, 1'b0);
    // Fault, acknowledge and switch-on inhibit
    level(M_ERR, 1'b1);
    chk_sw(16'h048F, 16'h0488);
    level(M_ERR, 1'b0);
    chk_sw(16'h0088, 16'h0088);
    put(16'h0489);
    put(16'h0409);
    chk_sw(16'h04C8, 16'h0440);
    put(16'h0408);
    chk_sw(16'h0040, 16'h0000);
    settle();
    chk_sw(16'h0400, 16'h0000);
    put(16'h0000);
    // Overcurrent forces fault from not ready
    level(M_OVC, 1'b1);
    chk_sw(16'h4008, 16'h4008);
    level(M_OVC, 1'b0);
    put(16'h0080);
    put(16'h0000);
    chk_sw(16'h4008, 16'h0000);
    put(16'h0001);
    put(16'h0000);
    chk_sw(16'h0040, 16'h0000);
    // Position limit
    level(M_OOR, 1'b1);
    chk_sw(16'h8000, 16'h8000);
    level(M_OOR, 1'b0);
    chk_sw(16'h8000, 16'h0000);
    close_out();
  end

  // Watchdog well beyond the roughly 120 cycles of the sequence
  initial begin
    repeat (4000) @(posedge clk_sys);
    num_errors++;
    close_out();
  end
endmodule : drive_status_word_logic_tb
`default_nettype wire
